// file: include/ltc_pkg.sv
package ltc_pkg;
    // Line trigger source selector codes
    localparam logic [2:0] SEL_SPLIT = 3'h0;
    localparam logic [2:0] SEL_ONLY_A = 3'h1;
    localparam logic [2:0] SEL_ONLY_B = 3'h2;
    localparam logic [2:0] SEL_BOARD_SYNC = 3'h4;
    // Direction qualification codes
    localparam logic [1:0] DIR_IGNORE = 2'h0;
    localparam logic [1:0] DIR_A_LEADS = 2'h1;
    localparam logic [1:0] DIR_B_LEADS = 2'h2;
    // Per-camera source kinds
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_A = 3'h1;
    localparam logic [2:0] SRC_B = 3'h2;
    localparam logic [2:0] SRC_AB = 3'h3;
    localparam logic [2:0] SRC_SYNC = 3'h4;
    // Default widths
    localparam int SET_W = 8;
    localparam int REV_W = 16;
    localparam int PERIOD_W = 20;
    localparam int GAP_W = 16;
    localparam int PEND_W = 4;
    // Clock
    localparam int CLK_PERIOD_PS = 5000;
    // Reset values
    localparam logic [1:0] PHASE_RST = 2'h0;
    typedef enum logic {GAP_OPEN, GAP_HOLD} ltc_gap_t;
endpackage : ltc_pkg

// file: rtl/ltc_pulse_mult.sv
`timescale 1ns/100ps
`default_nettype none
module ltc_pulse_mult #(
    parameter int SET_W = ltc_pkg::SET_W,
    parameter int PERIOD_W = ltc_pkg::PERIOD_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Stream
    input wire logic in_pulse,
    input wire logic [SET_W-1:0] multiply,
    output logic out_pulse
);
    logic [PERIOD_W-1:0] run_q, run_d, per_q, per_d, acc_q, acc_d;
    logic [SET_W-1:0] left_q, left_d, mult_eff;
    logic [PERIOD_W:0] acc_sum;
    logic out_q, out_d;

    if (PERIOD_W <= SET_W)
    begin : g_chk
        $error("PERIOD_W must exceed SET_W");
    end

    always_comb
    begin
        mult_eff = (multiply == '0) ? SET_W'(1) : multiply;
        acc_sum = {1'b0, acc_q} + (PERIOD_W+1)'(mult_eff);
        run_d = (run_q == '1) ? run_q : run_q + PERIOD_W'(1);
        per_d = per_q;
        acc_d = acc_q;
        left_d = left_q;
        out_d = 1'b0;
        if (in_pulse)
        begin
            per_d = run_d;
            run_d = '0;
            acc_d = '0;
            left_d = mult_eff - SET_W'(1);
            out_d = 1'b1;
        end
        else if (left_q != '0)
        begin
            // Adding the count each cycle spaces pulses by period/count
            if (acc_sum >= {1'b0, per_q})
            begin
                acc_d = PERIOD_W'(acc_sum - {1'b0, per_q});
                left_d = left_q - SET_W'(1);
                out_d = 1'b1;
            end
            else
            begin
                acc_d = acc_sum[PERIOD_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            run_q <= '0;
            per_q <= '0;
            acc_q <= '0;
            left_q <= '0;
            out_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            per_q <= per_d;
            acc_q <= acc_d;
            left_q <= left_d;
            out_q <= out_d;
        end
    end

    assign out_pulse = out_q;
endmodule : ltc_pulse_mult
`default_nettype wire

// file: rtl/ltc_quad_dec.sv
`timescale 1ns/100ps
`default_nettype none
module ltc_quad_dec (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Encoder phases
    input wire logic phase_a,
    input wire logic phase_b,
    // Decoded events
    output logic edge_a,
    output logic edge_b,
    output logic rise_a,
    output logic rise_b,
    output logic step_ab,
    output logic step_ba
);
    logic [1:0] s1_q, s2_q, s3_q;
    logic [5:0] ev_d, ev_q;
    logic [1:0] warm_q, warm_d;

    always_comb
    begin
        ev_d = '0;
        ev_d[0] = s2_q[1] ^ s3_q[1];
        ev_d[1] = s2_q[0] ^ s3_q[0];
        ev_d[2] = s2_q[1] & ~s3_q[1];
        ev_d[3] = s2_q[0] & ~s3_q[0];
        // Gray walk 00-10-11-01 means A leads B
        case ({s3_q, s2_q})
            4'h2, 4'hB, 4'hD, 4'h4: ev_d[4] = 1'b1;
            4'h8, 4'hE, 4'h7, 4'h1: ev_d[5] = 1'b1;
            default: ev_d[5:4] = 2'h0;
        endcase
        // No events while stages still hold reset values, not pin values
        if (warm_q != '1)
        begin
            ev_d = '0;
        end
        warm_d = (warm_q == '1) ? warm_q : warm_q + 2'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s1_q <= ltc_pkg::PHASE_RST;
            s2_q <= ltc_pkg::PHASE_RST;
            s3_q <= ltc_pkg::PHASE_RST;
            ev_q <= '0;
            warm_q <= '0;
        end
        else
        begin
            s1_q <= {phase_a, phase_b};
            s2_q <= s1_q;
            s3_q <= s2_q;
            ev_q <= ev_d;
            warm_q <= warm_d;
        end
    end

    assign edge_a = ev_q[0];
    assign edge_b = ev_q[1];
    assign rise_a = ev_q[2];
    assign rise_b = ev_q[3];
    assign step_ab = ev_q[4];
    assign step_ba = ev_q[5];
endmodule : ltc_quad_dec
`default_nettype wire

// file: rtl/ltc_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - external trigger path: one exposure per event
// - selector 0: cam1 A, cam2 B, full A/AB
// - selector 1: all paths use phase A
// - selector 2: all paths use phase B
// - 3,5,6,7 encoder only AB; 4 board sync
// - each path gated by its enable
// - encoder enable 1 on, 0 off
// - one line per encoder edge, then multiply/drop
// - undirected dual phase: any edge triggers
// - drop skips N pulses after each valid
// - multiply makes N pulses per encoder pulse
// - multiply first, then drop
// - direction 0 ignore, 1 A leads, 2 B leads
// - count reverse steps, forward after zero triggers
// - reverse counter overflow raises an event
// - auto delay holds early triggers, at most 15 pending (PEND_W 4), further ones lost
// - optional too-fast event under auto delay
module ltc_top #(
    parameter int SET_W = ltc_pkg::SET_W,
    parameter int REV_W = ltc_pkg::REV_W,
    parameter int PERIOD_W = ltc_pkg::PERIOD_W,
    parameter int GAP_W = ltc_pkg::GAP_W,
    parameter int PEND_W = ltc_pkg::PEND_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Trigger inputs
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    input wire logic board_sync_in,
    // Configuration
    input wire logic [2:0] src_sel,
    input wire logic full_camera,
    input wire logic ext_line_trigger_enable,
    input wire logic encoder_path_enable,
    input wire logic [SET_W-1:0] pulse_drop,
    input wire logic [SET_W-1:0] pulse_multiply,
    input wire logic [1:0] direction_mode,
    input wire logic auto_delay_enable,
    input wire logic [GAP_W-1:0] min_line_gap,
    input wire logic too_fast_event_enable,
    input wire logic rev_ovf_ack,
    // Camera triggers and status
    output logic [1:0] line_trig,
    output logic [1:0] too_fast_event,
    output logic rev_ovf_event,
    output logic [REV_W-1:0] rev_count
);
    logic edge_a, edge_b, rise_a, rise_b, step_ab, step_ba;
    logic sync_q, sync_rise;
    logic [REV_W-1:0] rev_q, rev_d;
    logic ovf_q, ovf_d;
    logic fwd, rev, qual_ab;

    if (SET_W < 1 || REV_W < 2 || GAP_W < 1 || PEND_W < 1)
    begin : g_chk
        $error("ltc_top parameter out of range");
    end

    ltc_quad_dec u_dec (
        .ref_clk(ref_clk),
        .rst(rst),
        .phase_a(phase_a_in),
        .phase_b(phase_b_in),
        .edge_a(edge_a),
        .edge_b(edge_b),
        .rise_a(rise_a),
        .rise_b(rise_b),
        .step_ab(step_ab),
        .step_ba(step_ba)
    );

    // Board sync edge, input already synchronous
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync_q <= 1'b0;
        end
        else
        begin
            sync_q <= board_sync_in;
        end
    end
    assign sync_rise = board_sync_in & ~sync_q;

    // Direction qualification and reverse step counter
    always_comb
    begin
        fwd = 1'b0;
        rev = 1'b0;
        case (direction_mode)
            ltc_pkg::DIR_A_LEADS:
            begin
                fwd = step_ab;
                rev = step_ba;
            end
            ltc_pkg::DIR_B_LEADS:
            begin
                fwd = step_ba;
                rev = step_ab;
            end
            default:
            begin
                fwd = 1'b0;
                rev = 1'b0;
            end
        endcase
        rev_d = rev_q;
        ovf_d = ovf_q & ~rev_ovf_ack;
        if (rev)
        begin
            if (rev_q == '1)
            begin
                ovf_d = 1'b1;
            end
            else
            begin
                rev_d = rev_q + REV_W'(1);
            end
        end
        else if (fwd && rev_q != '0)
        begin
            rev_d = rev_q - REV_W'(1);
        end
        if (direction_mode[0] == direction_mode[1]) // Codes 0 and 3
        begin
            qual_ab = edge_a | edge_b;
        end
        else
        begin
            qual_ab = fwd & (rev_q == '0);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rev_q <= '0;
            ovf_q <= 1'b0;
        end
        else
        begin
            rev_q <= rev_d;
            ovf_q <= ovf_d;
        end
    end

    assign rev_ovf_event = ovf_q;
    assign rev_count = rev_q;

    // Per-camera path: select, multiply, drop, auto delay
    for (genvar c = 0; c < 2; c++)
    begin : g_cam
        logic [2:0] line_src, enc_src;
        logic line_pulse, enc_pulse, mult_pulse, drop_ok, cand;
        logic [SET_W-1:0] drop_q, drop_d;
        logic [GAP_W-1:0] gap_q, gap_d;
        logic [PEND_W-1:0] pend_q, pend_d;
        ltc_pkg::ltc_gap_t st_q, st_d;
        logic trig_q, trig_d, fast_q, fast_d, issue;

        always_comb
        begin
            line_src = ltc_pkg::SRC_NONE;
            enc_src = ltc_pkg::SRC_AB;
            case (src_sel)
                ltc_pkg::SEL_SPLIT:
                begin
                    line_src = (c == 0 || full_camera) ? ltc_pkg::SRC_A
                                                      : ltc_pkg::SRC_B;
                    if (full_camera)
                    begin
                        enc_src = ltc_pkg::SRC_AB;
                    end
                    else
                    begin
                        enc_src = line_src;
                    end
                end
                ltc_pkg::SEL_ONLY_A:
                begin
                    line_src = ltc_pkg::SRC_A;
                    enc_src = ltc_pkg::SRC_A;
                end
                ltc_pkg::SEL_ONLY_B:
                begin
                    line_src = ltc_pkg::SRC_B;
                    enc_src = ltc_pkg::SRC_B;
                end
                ltc_pkg::SEL_BOARD_SYNC:
                begin
                    line_src = ltc_pkg::SRC_SYNC;
                    enc_src = ltc_pkg::SRC_SYNC;
                end
                default:
                begin
                    line_src = ltc_pkg::SRC_NONE;
                    enc_src = ltc_pkg::SRC_AB;
                end
            endcase
            case (line_src)
                ltc_pkg::SRC_A: line_pulse = rise_a;
                ltc_pkg::SRC_B: line_pulse = rise_b;
                ltc_pkg::SRC_SYNC: line_pulse = sync_rise;
                default: line_pulse = 1'b0;
            endcase
            case (enc_src)
                ltc_pkg::SRC_A: enc_pulse = edge_a;
                ltc_pkg::SRC_B: enc_pulse = edge_b;
                ltc_pkg::SRC_SYNC: enc_pulse = sync_rise;
                default: enc_pulse = qual_ab;
            endcase
            enc_pulse = enc_pulse & encoder_path_enable;
            line_pulse = line_pulse & ext_line_trigger_enable;
        end

        // Multiply ahead of the drop counter
        ltc_pulse_mult #(
            .SET_W(SET_W),
            .PERIOD_W(PERIOD_W)
        ) u_mult (
            .ref_clk(ref_clk),
            .rst(rst),
            .in_pulse(enc_pulse),
            .multiply(pulse_multiply),
            .out_pulse(mult_pulse)
        );

        always_comb
        begin
            drop_d = drop_q;
            drop_ok = 1'b0;
            if (mult_pulse)
            begin
                if (drop_q == '0)
                begin
                    drop_ok = 1'b1;
                    drop_d = pulse_drop;
                end
                else
                begin
                    drop_d = drop_q - SET_W'(1);
                end
            end
            cand = drop_ok | line_pulse;
        end

        // Auto delay: hold triggers until the line gap has passed
        always_comb
        begin
            st_d = st_q;
            gap_d = gap_q;
            pend_d = pend_q;
            issue = 1'b0;
            fast_d = 1'b0;
            if (!auto_delay_enable)
            begin
                issue = cand;
                st_d = ltc_pkg::GAP_OPEN;
                pend_d = '0;
            end
            else
            begin
                case (st_q)
                    ltc_pkg::GAP_OPEN:
                    begin
                        if (cand || pend_q != '0)
                        begin
                            issue = 1'b1;
                            if (!cand)
                            begin
                                pend_d = pend_q - PEND_W'(1);
                            end
                        end
                    end
                    ltc_pkg::GAP_HOLD:
                    begin
                        if (cand && pend_q != '1)
                        begin
                            pend_d = pend_q + PEND_W'(1);
                        end
                        fast_d = cand & too_fast_event_enable;
                    end
                    default:
                    begin
                        st_d = ltc_pkg::GAP_OPEN;
                    end
                endcase
            end
            if (gap_q != '0)
            begin
                gap_d = gap_q - GAP_W'(1);
            end
            if (gap_d == '0)
            begin
                st_d = ltc_pkg::GAP_OPEN;
            end
            if (issue && auto_delay_enable && min_line_gap > GAP_W'(1))
            begin
                gap_d = min_line_gap - GAP_W'(1);
                st_d = ltc_pkg::GAP_HOLD;
            end
            trig_d = issue;
        end

        always_ff @(posedge ref_clk)
        begin
            if (rst)
            begin
                drop_q <= '0;
                gap_q <= '0;
                pend_q <= '0;
                st_q <= ltc_pkg::GAP_OPEN;
                trig_q <= 1'b0;
                fast_q <= 1'b0;
            end
            else
            begin
                drop_q <= drop_d;
                gap_q <= gap_d;
                pend_q <= pend_d;
                st_q <= st_d;
                trig_q <= trig_d;
                fast_q <= fast_d;
            end
        end

        assign line_trig[c] = trig_q;
        assign too_fast_event[c] = fast_q;
    end
endmodule : ltc_top
`default_nettype wire

// file: verif/ltc_enc_model.sv
`timescale 1ns/100ps
`default_nettype none
module ltc_enc_model (
    // Clock
    input wire logic ref_clk,
    // Step request
    input wire logic step_req,
    input wire logic step_fwd,
    // Encoder phases
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] pos_q = 2'h0;

    // Forward walks 00, 10, 11, 01 on (A, B): A leads B
    always_ff @(posedge ref_clk)
    begin
        if (step_req)
            pos_q <= step_fwd ? pos_q + 2'h1 : pos_q - 2'h1;
    end

    assign phase_a = pos_q[1] ^ pos_q[0];
    assign phase_b = pos_q[1];
endmodule : ltc_enc_model
`default_nettype wire

// file: verif/ltc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ltc_top_monitor #(
    parameter int SET_W = ltc_pkg::SET_W,
    parameter int REV_W = ltc_pkg::REV_W,
    parameter int GAP_W = ltc_pkg::GAP_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Watched inputs
    input wire logic board_sync_in,
    input wire logic [2:0] src_sel,
    input wire logic ext_line_trigger_enable,
    input wire logic encoder_path_enable,
    input wire logic [SET_W-1:0] pulse_drop,
    input wire logic auto_delay_enable,
    input wire logic [GAP_W-1:0] min_line_gap,
    input wire logic too_fast_event_enable,
    input wire logic rev_ovf_ack,
    // Watched outputs
    input wire logic [1:0] line_trig,
    input wire logic [1:0] too_fast_event,
    input wire logic rev_ovf_event,
    input wire logic [REV_W-1:0] rev_count
);
    logic [GAP_W-1:0] gap_q;
    logic [GAP_W-1:0] gap_d;
    logic seen_q;
    logic seen_d;

    // Cycles since last camera 1 trigger, auto delay on throughout
    always_comb
    begin
        gap_d = (gap_q == '1) ? gap_q : gap_q + 1'b1;
        seen_d = seen_q && auto_delay_enable;
        if (line_trig[0])
        begin
            gap_d = GAP_W'(1);
            seen_d = auto_delay_enable;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q <= gap_d;
            seen_q <= seen_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    reset_clear_a: assert property (disable iff (1'b0)
        rst |=> line_trig == 2'h0 && rev_ovf_event == 1'b0
        && rev_count == '0)
        else $error("outputs not cleared by reset");
    ovf_hold_a: assert property (
        rev_ovf_event && !rev_ovf_ack |=> rev_ovf_event)
        else $error("overflow flag dropped without ack");
    ovf_at_max_a: assert property (
        $rose(rev_ovf_event) |-> rev_count == '1)
        else $error("overflow flag set below counter maximum");
    rev_step_a: assert property (
        !$past(rst) && rev_count != $past(rev_count) |->
        (rev_count == $past(rev_count) + 1'b1 && $past(rev_count) != '1)
        || (rev_count == $past(rev_count) - 1'b1 && $past(rev_count) != '0))
        else $error("reverse counter jumped or wrapped");
    tf_gate_a: assert property (
        too_fast_event != 2'h0 |-> $past(too_fast_event_enable))
        else $error("too fast event while disabled");
    tf_auto_a: assert property (
        too_fast_event != 2'h0 |-> $past(auto_delay_enable))
        else $error("too fast event without auto delay");
    trig_spacing_a: assert property (
        line_trig[0] && seen_q && auto_delay_enable && min_line_gap > 1
        |-> gap_q >= min_line_gap)
        else $error("line triggers closer than minimum gap");
    sync_follow_a: assert property (
        $rose(board_sync_in) && src_sel == ltc_pkg::SEL_BOARD_SYNC
        && ext_line_trigger_enable && !encoder_path_enable
        && !auto_delay_enable && pulse_drop == '0
        |-> ##[1:2] line_trig == 2'h3)
        else $error("board sync edge gave no camera triggers");
endmodule : ltc_top_monitor

bind ltc_top ltc_top_monitor #(.SET_W(SET_W), .REV_W(REV_W), .GAP_W(GAP_W))
    ltc_top_monitor_i (.ref_clk(ref_clk), .rst(rst),
    .board_sync_in(board_sync_in), .src_sel(src_sel),
    .ext_line_trigger_enable(ext_line_trigger_enable),
    .encoder_path_enable(encoder_path_enable), .pulse_drop(pulse_drop),
    .auto_delay_enable(auto_delay_enable), .min_line_gap(min_line_gap),
    .too_fast_event_enable(too_fast_event_enable),
    .rev_ovf_ack(rev_ovf_ack), .line_trig(line_trig),
    .too_fast_event(too_fast_event), .rev_ovf_event(rev_ovf_event),
    .rev_count(rev_count));
`default_nettype wire

// file: verif/ltc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ltc_top_tb_top;
    localparam int REV_W = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic step_req = 1'b0;
    logic step_fwd = 1'b1;
    logic phase_a;
    logic phase_b;
    logic board_sync_in = 1'b0;
    logic [2:0] src_sel = 3'h0;
    logic full_camera = 1'b0;
    logic ext_en = 1'b0;
    logic enc_en = 1'b0;
    logic [7:0] drop = 8'h00;
    logic [7:0] mult = 8'h01;
    logic [1:0] dir_mode = 2'h0;
    logic auto_en = 1'b0;
    logic [15:0] gap = 16'h0000;
    logic tf_en = 1'b0;
    logic ack = 1'b0;
    logic [1:0] line_trig;
    logic [1:0] too_fast;
    logic ovf;
    logic [REV_W-1:0] rev_count;
    int c0 = 0;
    int c1 = 0;
    int f0 = 0;
    int f1 = 0;
    int n_mismatch = 0;
    int tests_run = 0;

    initial forever #2.5 ref_clk = ~ref_clk;

    ltc_enc_model ltc_enc_model_i (.ref_clk(ref_clk), .step_req(step_req),
        .step_fwd(step_fwd), .phase_a(phase_a), .phase_b(phase_b));

    ltc_top #(.REV_W(REV_W)) ltc_top_i (.ref_clk(ref_clk), .rst(rst),
        .phase_a_in(phase_a), .phase_b_in(phase_b),
        .board_sync_in(board_sync_in), .src_sel(src_sel),
        .full_camera(full_camera), .ext_line_trigger_enable(ext_en),
        .encoder_path_enable(enc_en), .pulse_drop(drop),
        .pulse_multiply(mult), .direction_mode(dir_mode),
        .auto_delay_enable(auto_en), .min_line_gap(gap),
        .too_fast_event_enable(tf_en), .rev_ovf_ack(ack),
        .line_trig(line_trig), .too_fast_event(too_fast),
        .rev_ovf_event(ovf), .rev_count(rev_count));

    always @(posedge ref_clk)
    begin
        c0 += int'(line_trig[0] === 1'b1);
        c1 += int'(line_trig[1] === 1'b1);
        f0 += int'(too_fast[0] === 1'b1);
        f1 += int'(too_fast[1] === 1'b1);
        if (!rst && $isunknown({line_trig, too_fast}))
            check("known", {line_trig, too_fast}, '0);
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic restart;
        rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        check("reset", {line_trig, ovf, rev_count}, '0);
        repeat (4) @(negedge ref_clk);
        c0 = 0;
        c1 = 0;
        f0 = 0;
        f1 = 0;
    endtask : restart

    task automatic steps(input int n, input logic fwd, input int sp,
        input int drain);
        for (int i = 0; i < n; i++)
        begin
            step_fwd = fwd;
            step_req = 1'b1;
            @(negedge ref_clk);
            step_req = 1'b0;
            repeat (sp - 1) @(negedge ref_clk);
        end
        repeat (drain) @(negedge ref_clk);
    endtask : steps

    // Triggers per camera for 4k forward steps: k rises (line path) or 2k edges (encoder path) per phase
    function automatic int exp_cnt(int sel, bit full, int cam, bit enc,
        int k);
        int src;
        case (sel)
            0: src = (full || cam == 0) ? ((enc && full) ? 3 : 1) : 2;
            1: src = 1;
            2: src = 2;
            4: src = 0;
            default: src = enc ? 3 : 0;
        endcase
        if (src == 0)
            return 0;
        if (src == 3)
            return 4 * k;
        return enc ? 2 * k : k;
    endfunction : exp_cnt

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        int k;
        int d;
        int m;
        void'($urandom(32'hF85F1595));
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        for (int s = 0; s < 8; s++)
            for (int p = 0; p < 4; p++)
            begin
                k = 1 + $urandom_range(1);
                src_sel = s[2:0];
                enc_en = p[0];
                ext_en = !p[0];
                full_camera = p[1];
                dir_mode = ($urandom_range(1) != 0) ? 2'h3 : 2'h0;
                restart();
                steps(4 * k, 1'b1, 6 + $urandom_range(4), 16);
                check("cam1", c0, exp_cnt(s, p[1], 0, p[0], k));
                check("cam2", c1, exp_cnt(s, p[1], 1, p[0], k));
            end
        full_camera = 1'b0;
        enc_en = 1'b0;
        dir_mode = 2'h0;
        src_sel = ltc_pkg::SEL_BOARD_SYNC;
        for (int e = 0; e < 3; e++)
        begin
            k = 1 + $urandom_range(3);
            ext_en = (e == 1);
            enc_en = (e == 2);
            restart();
            repeat (k)
            begin
                board_sync_in = 1'b1;
                @(negedge ref_clk);
                board_sync_in = 1'b0;
                repeat (5) @(negedge ref_clk);
            end
            check("sync", c0 + c1, (e != 0) ? 2 * k : 0);
        end
        src_sel = 3'h3;
        ext_en = 1'b0;
        enc_en = 1'b1;
        for (int r = 0; r < 4; r++)
        begin
            d = (r == 0) ? 2 : $urandom_range(3);
            m = 1 + $urandom_range(2);
            drop = d[7:0];
            mult = m[7:0];
            restart();
            steps(8, 1'b1, 64, 80);
            check("mult_drop", c0, (8 * m + d) / (d + 1));
        end
        drop = 8'h00;
        mult = 8'h01;
        for (int r = 1; r < 3; r++)
        begin
            dir_mode = r[1:0];
            restart();
            steps(4, r != 1, 6, 16);
            check("rev_up", rev_count, 4);
            steps(4, r == 1, 6, 16);
            check("rev_down", rev_count, 0);
            check("held", c0, 0);
            steps(4, r == 1, 6, 16);
            check("fwd", c0, 4);
        end
        dir_mode = 2'h1;
        restart();
        steps(16, 1'b0, 6, 16);
        check("sat", rev_count, 15);
        check("ovf", ovf, 1);
        repeat (20) @(negedge ref_clk);
        check("ovf_hold", ovf, 1);
        ack = 1'b1;
        @(negedge ref_clk);
        ack = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("ovf_clr", ovf, 0);
        dir_mode = 2'h0;
        auto_en = 1'b1;
        gap = 16'h0028;
        for (int t = 0; t < 2; t++)
        begin
            tf_en = t[0];
            restart();
            steps(8, 1'b1, 4, 340);
            check("spaced", c0, 8);
            check("too_fast", f0, 7 * t);
            check("spaced2", c1, 8);
            check("too_fast2", f1, 7 * t);
        end
        end_sim();
    end
endmodule : ltc_top_tb_top
`default_nettype wire
